/* File: src/hostport_device.sv */
// Device end: local transfer handshake, interrupts, DMA requests, interconnect port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE1: Read or write command starts a transfer.
// RULE2: Wait asserted at command, released when done.
// RULE3: Host holds command until wait released.
// RULE4: Message events drive the message interrupt.
// RULE5: Errors drive error interrupt; details kept.
// RULE6: Output DMA request while output FIFO empty.
// RULE7: DMA fills output FIFO on request.
// RULE8: Input DMA request on full, drop on empty.
// RULE9: Output acknowledge qualified by a command.
// RULE10: Input acknowledge qualified by a command.
// RULE11: At most one select or acknowledge active.
// RULE12: Eight-bit bus carries address then data.
// RULE13: Read request raised right after address match.
// RULE14: Write request waits for data-valid line.
// RULE15: Request suppressed while interconnect locked.
// RULE16: Microcontroller pulses address strobe cleanly.
// RULE17: Microcontroller read or write strobes cleanly.
// RULE18: Both strobes together disable all outputs; here rdata and the ACC_START_O to ACC_WDATA_O outputs stay driven.
// RULE19: Selects give memory, I/O or register access.
// RULE20: Address lines five to two pick register.
// RULE21: Host never overlaps or combines commands.
module hostport_device #(
  parameter int SYNC_CYCLES = hostport_pkg::SYNC_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  hostport_if.device       port,
  // Internal event and status inputs from the rest of the controller.
  input  wire logic        UNSOL_MSG_I,
  input  wire logic        TX_FIFO_FREE_I,
  input  wire logic        SOL_DONE_I,
  input  wire logic        MSG_ERR_I,
  input  wire logic        REF_ERR_I,
  input  wire logic [7:0]  REF_ERR_CODE_I,
  input  wire logic        OUT_PHASE_I,
  input  wire logic        OUT_FIFO_EMPTY_I,
  input  wire logic        IN_PHASE_I,
  input  wire logic        IN_FIFO_FULL_I,
  input  wire logic        IN_FIFO_EMPTY_I,
  input  wire logic        IC_MATCH_I,
  input  wire logic        IC_IS_WRITE_I,
  input  wire logic        SYSBUS_DATA_VALID_CTL_I,
  input  wire logic        IC_LOCK_I,
  input  wire logic        IRQ_CLR_I,
  input  wire logic [31:0] REG_RDATA_I,
  output logic             ACC_START_O,
  output var hostport_pkg::access_kind_t ACC_KIND_O,
  output logic [3:0]       ACC_REG_O,
  output logic             ACC_WRITE_O,
  output logic [31:0]      ACC_WDATA_O
);

  // ------------------------------------------------------------
  // Local access decode
  // ------------------------------------------------------------

  // Selects and acknowledges are mutually exclusive; priority only guards misuse.
  wire cmd_active = !port.rd_n || !port.wr_n;                      // see RULE1
  hostport_pkg::access_kind_t kind;
  assign kind = port.memory_select       ? hostport_pkg::ACC_MEM :     // see RULE19
                port.io_select           ? hostport_pkg::ACC_IO :
                port.register_select     ? hostport_pkg::ACC_REG :
                port.in_dma_acknowledge  ? hostport_pkg::ACC_IN_DMA :  // see RULE10
                port.out_dma_acknowledge ? hostport_pkg::ACC_OUT_DMA : // see RULE9
                hostport_pkg::ACC_NONE;                                 // see RULE11

  typedef enum logic [1:0] {S_IDLE, S_BUSY, S_DONE} acc_state_t;
  acc_state_t  state_q, state_d;
  logic [15:0] cnt_q;
  logic [31:0] rdata_q;
  logic        start_q;
  hostport_pkg::access_kind_t kind_q;
  logic [3:0]  reg_q;
  logic        write_q;
  logic [31:0] wdata_q;

  // The host holds its command through wait, so the state waits for release.
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (cmd_active) state_d = S_BUSY;                   // see RULE3
      S_BUSY: if (cnt_q == 16'(SYNC_CYCLES - 1)) state_d = S_DONE;
      S_DONE: if (!cmd_active) state_d = S_IDLE;                  // see RULE21
      default: state_d = S_IDLE;
    endcase
  end

  // Sequencer and captured access fields.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= S_IDLE;
      cnt_q   <= 16'h0000;
      rdata_q <= hostport_pkg::DATA_RST;
      start_q <= 1'b0;
      kind_q  <= hostport_pkg::ACC_NONE;
      reg_q   <= 4'h0;
      write_q <= 1'b0;
      wdata_q <= hostport_pkg::DATA_RST;
    end else begin
      state_q <= state_d;
      start_q <= (state_q == S_IDLE) && cmd_active;
      cnt_q   <= (state_q == S_BUSY) ? cnt_q + 16'h0001 : 16'h0000;
      if ((state_q == S_IDLE) && cmd_active) begin
        kind_q  <= kind;
        reg_q   <= port.addr;                                     // see RULE20
        write_q <= !port.wr_n;
        wdata_q <= port.wdata;
      end
      if (state_d == S_DONE && state_q == S_BUSY) begin
        rdata_q <= REG_RDATA_I;
      end
    end
  end

  // Wait is combinational so it rises in the very cycle the command appears.
  wire wait_act = (cmd_active && state_q == S_IDLE) || state_q == S_BUSY; // see RULE2

  // ------------------------------------------------------------
  // Interrupts and DMA requests
  // ------------------------------------------------------------

  logic       msg_q, err_q, in_req_q;
  logic [7:0] err_code_q;
  wire        msg_ev = UNSOL_MSG_I || TX_FIFO_FREE_I || SOL_DONE_I || MSG_ERR_I;

  // Sticky lines; a new interrupt event in the clearing cycle wins over the clear; the input DMA drop wins over full.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      msg_q      <= 1'b0;
      err_q      <= 1'b0;
      err_code_q <= hostport_pkg::IC_RST;
      in_req_q   <= 1'b0;
    end else begin
      msg_q <= msg_ev || (msg_q && !IRQ_CLR_I);                   // see RULE4
      err_q <= REF_ERR_I || (err_q && !IRQ_CLR_I);                // see RULE5
      if (REF_ERR_I) err_code_q <= REF_ERR_CODE_I;                // see RULE5
      if (!IN_PHASE_I || IN_FIFO_EMPTY_I) in_req_q <= 1'b0;        // see RULE8
      else if (IN_FIFO_FULL_I) in_req_q <= 1'b1;
    end
  end

  wire out_req = OUT_PHASE_I && OUT_FIFO_EMPTY_I;                  // see RULE6

  // ------------------------------------------------------------
  // Interconnect port
  // ------------------------------------------------------------

  logic [7:0] ic_addr_q;
  logic       ic_pend_q;
  logic       ic_arm_q;
  wire        test_off = port.ic_read_strobe && port.ic_write_strobe; // see RULE18

  // Window test by offset from its base, so a zero base needs no always-true compare.
  wire        ic_hit   = (ic_addr_q - hostport_pkg::IC_REG_FIRST) <=
                         (hostport_pkg::IC_REG_LAST - hostport_pkg::IC_REG_FIRST);

  // A write match may come before the data-valid line; it stays armed until then.
  // Without the arm, a match and data valid in different cycles would be lost.
  wire        ic_wr_match = IC_MATCH_I && IC_IS_WRITE_I;
  wire        ic_rd_fire  = IC_MATCH_I && !IC_IS_WRITE_I;                     // see RULE13
  wire        ic_wr_fire  = (ic_wr_match || ic_arm_q) && SYSBUS_DATA_VALID_CTL_I; // see RULE14
  wire        ic_fire     = ic_rd_fire || ic_wr_fire;

  // Address latched on the strobe, data follows on the same lines.
  // A new request in the cycle of a strobe wins, so it is never dropped.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ic_addr_q <= hostport_pkg::IC_RST;
      ic_pend_q <= 1'b0;
      ic_arm_q  <= 1'b0;
    end else begin
      if (port.ic_address_strobe) ic_addr_q <= port.ic_addr_data_bus;  // see RULE12
      if (ic_fire) begin
        ic_pend_q <= 1'b1;                                            // see RULE13
      end else if (port.ic_read_strobe || port.ic_write_strobe) begin
        ic_pend_q <= 1'b0;
      end
      if (ic_wr_fire) begin
        ic_arm_q <= 1'b0;
      end else if (ic_wr_match) begin
        ic_arm_q <= 1'b1;                                             // see RULE14
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs; wait, interrupts, DMA requests and interconnect request and drive forced inactive in test isolation
  // ------------------------------------------------------------

  assign port.wait_n          = test_off ? 1'b1 : !wait_act;
  assign port.rdata           = rdata_q;
  assign port.message_irq     = !test_off && msg_q;
  assign port.error_irq       = !test_off && err_q;
  assign port.out_dma_request = !test_off && out_req;
  assign port.in_dma_request  = !test_off && in_req_q;
  assign port.ic_request      = !test_off && ic_pend_q && !IC_LOCK_I; // see RULE15
  assign port.ic_ad_dev       = ic_hit ? err_code_q : 8'h00;
  assign port.ic_ad_dev_oe    = !test_off && port.ic_read_strobe && ic_hit;
  assign port.outputs_enabled = !test_off;
  assign ACC_START_O = start_q;
  assign ACC_KIND_O  = kind_q;
  assign ACC_REG_O   = reg_q;
  assign ACC_WRITE_O = write_q;
  assign ACC_WDATA_O = wdata_q;

endmodule
`default_nettype wire

/* File: src/hostport_host.sv */
// Far-side end: host command issue, DMA acknowledges and microcontroller strobes.
`timescale 1ns/10ps
`default_nettype none
module hostport_host (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  hostport_if.host         port,
  input  wire logic        REQ_I,
  input  wire logic        REQ_WRITE_I,
  input  wire hostport_pkg::access_kind_t REQ_KIND_I,
  input  wire logic [3:0]  REQ_ADDR_I,
  input  wire logic [31:0] REQ_WDATA_I,
  input  wire logic        IC_GO_I,
  input  wire logic        IC_WRITE_I,
  input  wire logic [7:0]  IC_ADDR_I,
  input  wire logic [7:0]  IC_WDATA_I,
  input  wire logic        TEST_ISO_I,
  output logic             REQ_READY_O,
  output logic             DONE_O,
  output logic [31:0]      RDATA_O,
  output logic             IC_DONE_O,
  output logic [7:0]       IC_RDATA_O
);

  typedef enum logic [1:0] {H_IDLE, H_CMD, H_REL} host_state_t;
  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA} mcu_state_t;
  host_state_t hs_q;
  mcu_state_t  ms_q;
  logic        rd_q, wr_q, done_q, ic_done_q, icw_q;
  hostport_pkg::access_kind_t kind_q;
  logic [3:0]  addr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [7:0]  ica_q, icd_q, icr_q;

  // ------------------------------------------------------------
  // Host command: one at a time, held until wait drops
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hs_q <= H_IDLE; rd_q <= 1'b0; wr_q <= 1'b0; done_q <= 1'b0;
      kind_q <= hostport_pkg::ACC_NONE; addr_q <= 4'h0;
      wdata_q <= hostport_pkg::DATA_RST; rdata_q <= hostport_pkg::DATA_RST;
    end else begin
      done_q <= 1'b0;
      case (hs_q)
        H_IDLE: if (REQ_I) begin
          hs_q <= H_CMD; rd_q <= !REQ_WRITE_I; wr_q <= REQ_WRITE_I;    // see RULE21
          kind_q <= REQ_KIND_I; addr_q <= REQ_ADDR_I; wdata_q <= REQ_WDATA_I;
        end
        H_CMD: if (port.wait_n) begin                                 // see RULE3
          hs_q <= H_REL; rd_q <= 1'b0; wr_q <= 1'b0;
          rdata_q <= port.rdata; done_q <= 1'b1;
        end
        default: begin
          hs_q <= H_IDLE;
          kind_q <= hostport_pkg::ACC_NONE;
        end
      endcase
    end
  end

  // One-hot selects from the held kind keep them exclusive.
  assign port.rd_n                = !rd_q;
  assign port.wr_n                = !wr_q;
  assign port.addr                = addr_q;
  assign port.wdata               = wdata_q;
  assign port.memory_select       = kind_q == hostport_pkg::ACC_MEM;     // see RULE11
  assign port.io_select           = kind_q == hostport_pkg::ACC_IO;
  assign port.register_select     = kind_q == hostport_pkg::ACC_REG;
  assign port.in_dma_acknowledge  = kind_q == hostport_pkg::ACC_IN_DMA;  // see RULE10
  assign port.out_dma_acknowledge = kind_q == hostport_pkg::ACC_OUT_DMA; // see RULE9
  assign REQ_READY_O = hs_q == H_IDLE;
  assign DONE_O      = done_q;
  assign RDATA_O     = rdata_q;

  // ------------------------------------------------------------
  // Microcontroller: address strobe pulse, then one data strobe
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ms_q <= M_IDLE; ica_q <= 8'h00; icd_q <= 8'h00; icr_q <= 8'h00;
      icw_q <= 1'b0; ic_done_q <= 1'b0;
    end else begin
      ic_done_q <= 1'b0;
      case (ms_q)
        M_IDLE: if (IC_GO_I) begin
          ms_q <= M_ADDR; ica_q <= IC_ADDR_I; icd_q <= IC_WDATA_I; icw_q <= IC_WRITE_I;
        end
        M_ADDR: ms_q <= M_DATA;                                        // see RULE16
        default: begin
          ms_q <= M_IDLE; ic_done_q <= 1'b1;
          if (!icw_q) icr_q <= port.ic_addr_data_bus;                  // see RULE17
        end
      endcase
    end
  end

  assign port.ic_address_strobe = ms_q == M_ADDR;
  // Board test isolation raises both strobes together.
  assign port.ic_read_strobe    = (ms_q == M_DATA && !icw_q) || TEST_ISO_I; // see RULE18
  assign port.ic_write_strobe   = (ms_q == M_DATA && icw_q) || TEST_ISO_I;
  assign port.ic_ad_mcu         = (ms_q == M_ADDR) ? ica_q : icd_q;   // see RULE12
  assign port.ic_ad_mcu_oe      = ms_q == M_ADDR || (ms_q == M_DATA && icw_q);
  assign IC_DONE_O  = ic_done_q;
  assign IC_RDATA_O = icr_q;

endmodule
`default_nettype wire

/* File: src/hostport_if.sv */
// Interface joining the device end and the far-side end of the host port.
`timescale 1ns/10ps
`default_nettype none
interface hostport_if;
  // Local bus transfer control.
  logic        rd_n;
  logic        wr_n;
  logic        wait_n;
  logic [3:0]  addr;
  logic        memory_select;
  logic        io_select;
  logic        register_select;
  logic [31:0] wdata;
  logic [31:0] rdata;
  // Interrupts.
  logic        message_irq;
  logic        error_irq;
  // DMA pairs.
  logic        out_dma_request;
  logic        in_dma_request;
  logic        out_dma_acknowledge;
  logic        in_dma_acknowledge;
  // Interconnect port; each driver has its own output and enable.
  logic [7:0]  ic_ad_dev;
  logic        ic_ad_dev_oe;
  logic [7:0]  ic_ad_mcu;
  logic        ic_ad_mcu_oe;
  logic [7:0]  ic_addr_data_bus;
  logic        ic_request;
  logic        ic_address_strobe;
  logic        ic_read_strobe;
  logic        ic_write_strobe;
  logic        outputs_enabled;

  // Resolved bus level: the driving party wins, otherwise it floats high.
  assign ic_addr_data_bus = ic_ad_dev_oe ? ic_ad_dev :
                            (ic_ad_mcu_oe ? ic_ad_mcu : 8'hFF);

  modport device (
    input  rd_n, wr_n, addr, memory_select, io_select, register_select, wdata,
           out_dma_acknowledge, in_dma_acknowledge,
           ic_addr_data_bus, ic_address_strobe, ic_read_strobe, ic_write_strobe,
    output wait_n, rdata, message_irq, error_irq, out_dma_request, in_dma_request,
           ic_ad_dev, ic_ad_dev_oe, ic_request, outputs_enabled
  );

  modport host (
    output rd_n, wr_n, addr, memory_select, io_select, register_select, wdata,
           out_dma_acknowledge, in_dma_acknowledge,
           ic_ad_mcu, ic_ad_mcu_oe, ic_address_strobe, ic_read_strobe,
           ic_write_strobe,
    input  wait_n, rdata, message_irq, error_irq, out_dma_request, in_dma_request,
           ic_addr_data_bus, ic_request, outputs_enabled
  );
endinterface
`default_nettype wire

/* File: src/hostport_pkg.sv */
// Shared constants and types for the local host port and interconnect port.
package hostport_pkg;

  // Widths of the local address field, the interconnect bus and the local data bus.
  localparam int ADDR_W = 4;
  localparam int IC_W   = 8;
  localparam int DATA_W = 32;

  // Window of interconnect register addresses that the device answers on a read.
  localparam logic [7:0] IC_REG_FIRST = 8'h00;
  localparam logic [7:0] IC_REG_LAST  = 8'h1F;

  // Fixed cycles a synchronised access waits for its other resource.
  localparam int SYNC_NS     = 50;
  localparam int CLK_NS      = 10;
  localparam int SYNC_CYCLES = (SYNC_NS + CLK_NS - 1) / CLK_NS;

  // Reset values.
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [7:0]  IC_RST   = 8'h00;

  // Kind of local access, decoded from the selects.
  typedef enum logic [2:0] {
    ACC_NONE,
    ACC_MEM,
    ACC_IO,
    ACC_REG,
    ACC_IN_DMA,
    ACC_OUT_DMA
  } access_kind_t;

endpackage

/* File: tb/hostport_monitor.sv */
// Checker of the signals that join the device end and the far-side end.
`timescale 1ns/10ps
`default_nettype none
module hostport_monitor (
  input wire logic       CLK_I,
  input wire logic       NRST_I,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       wait_n,
  input wire logic [3:0] addr,
  input wire logic       memory_select,
  input wire logic       io_select,
  input wire logic       register_select,
  input wire logic       out_dma_acknowledge,
  input wire logic       in_dma_acknowledge,
  input wire logic       ic_ad_dev_oe,
  input wire logic       ic_ad_mcu_oe,
  input wire logic       ic_request,
  input wire logic       ic_read_strobe,
  input wire logic       ic_write_strobe
);
  // ---------------------------------------------------------------
  // Handshake and bus ownership checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  wire logic       cmd;
  wire logic [4:0] sel;
  // A command is active while either strobe is low.
  assign cmd = !rd_n || !wr_n;
  assign sel = {memory_select, io_select, register_select, in_dma_acknowledge,
                out_dma_acknowledge};
  wait_start_a: assert property ($fell(rd_n) || $fell(wr_n) |-> !wait_n)
    else $error("wait not raised with the command");
  wait_done_a: assert property ($fell(wait_n) |-> !wait_n [*6] ##1 wait_n)
    else $error("wait length wrong");
  cmd_hold_a: assert property (cmd && !wait_n |=> cmd)
    else $error("command dropped while wait active");
  cmd_excl_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write commands together");
  sel_one_a: assert property (cmd |-> $onehot0(sel))
    else $error("more than one select active");
  qual_hold_a: assert property (cmd && $past(cmd) |-> $stable({addr, sel}))
    else $error("qualified inputs moved in a command");
  bus_owner_a: assert property (!(ic_ad_dev_oe && ic_ad_mcu_oe))
    else $error("both ends drive the interconnect bus");
  dev_drive_a: assert property (ic_ad_dev_oe |->
    ic_read_strobe || $past(ic_read_strobe))
    else $error("device drives bus without a read strobe");
  req_clear_a: assert property ($rose(ic_read_strobe) || $rose(ic_write_strobe) |->
    ##[1:2] !ic_request)
    else $error("interconnect request not cleared");
  iso_off_a: assert property (ic_read_strobe && ic_write_strobe |->
    !ic_request && !ic_ad_dev_oe && wait_n)
    else $error("outputs active in test isolation");
  // Main scenarios reached.
  cover property ($fell(wait_n));
  cover property (ic_ad_dev_oe);
  cover property ($rose(ic_request));
  cover property (ic_read_strobe && ic_write_strobe);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the device end and the far-side end of the host port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        CLK_I = 1'b0;
  logic        NRST_I = 1'b0;
  logic        unsol, txf, sold, merr, rerr, oph, oemp, iph, ifull, iemp;
  logic        icm, icw, dval, lock, iclr, req, reqw, icgo, icwr, iso;
  logic        acc_start, acc_write, ready, done, icdone;
  logic [7:0]  ecode, icaddr, icwd, icrd;
  logic [3:0]  reqa, acc_reg;
  logic [31:0] regrd, reqwd, acc_wd, rdata;
  logic [39:0] qa[$];
  hostport_pkg::access_kind_t reqk, acc_kind;
  int          err_count = 0;
  int          cmp_count = 0;
  hostport_if bus_if ();
  hostport_device #(.SYNC_CYCLES(5)) hostport_device_inst (.CLK_I(CLK_I), .NRST_I(NRST_I),
    .port(bus_if.device), .UNSOL_MSG_I(unsol), .TX_FIFO_FREE_I(txf), .SOL_DONE_I(sold),
    .MSG_ERR_I(merr), .REF_ERR_I(rerr), .REF_ERR_CODE_I(ecode), .OUT_PHASE_I(oph),
    .OUT_FIFO_EMPTY_I(oemp), .IN_PHASE_I(iph), .IN_FIFO_FULL_I(ifull), .IN_FIFO_EMPTY_I(iemp),
    .IC_MATCH_I(icm), .IC_IS_WRITE_I(icw), .SYSBUS_DATA_VALID_CTL_I(dval), .IC_LOCK_I(lock),
    .IRQ_CLR_I(iclr), .REG_RDATA_I(regrd), .ACC_START_O(acc_start), .ACC_KIND_O(acc_kind),
    .ACC_REG_O(acc_reg), .ACC_WRITE_O(acc_write), .ACC_WDATA_O(acc_wd));
  hostport_host hostport_host_inst (.CLK_I(CLK_I), .NRST_I(NRST_I), .port(bus_if.host),
    .REQ_I(req), .REQ_WRITE_I(reqw), .REQ_KIND_I(reqk), .REQ_ADDR_I(reqa), .REQ_WDATA_I(reqwd),
    .IC_GO_I(icgo), .IC_WRITE_I(icwr), .IC_ADDR_I(icaddr), .IC_WDATA_I(icwd), .TEST_ISO_I(iso),
    .REQ_READY_O(ready), .DONE_O(done), .RDATA_O(rdata), .IC_DONE_O(icdone), .IC_RDATA_O(icrd));
  hostport_monitor hostport_monitor_inst (.CLK_I(CLK_I), .NRST_I(NRST_I), .rd_n(bus_if.rd_n),
    .wr_n(bus_if.wr_n), .wait_n(bus_if.wait_n), .addr(bus_if.addr),
    .memory_select(bus_if.memory_select), .io_select(bus_if.io_select),
    .register_select(bus_if.register_select), .out_dma_acknowledge(bus_if.out_dma_acknowledge),
    .in_dma_acknowledge(bus_if.in_dma_acknowledge), .ic_ad_dev_oe(bus_if.ic_ad_dev_oe),
    .ic_ad_mcu_oe(bus_if.ic_ad_mcu_oe), .ic_request(bus_if.ic_request),
    .ic_read_strobe(bus_if.ic_read_strobe), .ic_write_strobe(bus_if.ic_write_strobe));
  // The clock toggles every half period of 5 ns.
  always #5 CLK_I = ~CLK_I;
  // ---------------------------------------------------------------
  // Compare tasks, drivers and the model
  // ---------------------------------------------------------------
  task automatic chk_bit(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_vec(string nm, logic [39:0] e, logic [39:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One-cycle event pulse, raised and dropped on falling edges.
  task automatic pulse(ref logic s);
    @(negedge CLK_I);
    s = 1'b1;
    @(negedge CLK_I);
    s = 1'b0;
    #1;
  endtask
  // Local transfer; the model queue holds what the device must report at its start.
  task automatic local_op(logic w, int k, logic [3:0] a);
    int n;
    @(negedge CLK_I);
    {req, reqw, reqa} = {1'b1, w, a};
    reqk = hostport_pkg::access_kind_t'(k);
    reqwd = $urandom();
    regrd = $urandom();
    qa.push_back({reqk, a, w, w ? reqwd : 32'h0000_0000});
    for (n = 0; n < 50 && ready !== 1'b1; n++) @(posedge CLK_I);
    @(posedge CLK_I);
    @(negedge CLK_I);
    req = 1'b0;
    for (n = 0; n < 50 && done !== 1'b1; n++) begin
      @(posedge CLK_I);
      #1;
    end
    chk_bit("done", 1'b1, done);
    if (!w) chk_vec("rdata", {8'h00, regrd}, {8'h00, rdata});
  endtask
  // Microcontroller cycle on the interconnect bus; a floating bus reads high.
  task automatic ic_op(logic w, logic [7:0] a, logic [7:0] e);
    int n;
    @(negedge CLK_I);
    {icgo, icwr, icaddr} = {1'b1, w, a};
    icwd = $urandom();
    @(negedge CLK_I);
    icgo = 1'b0;
    for (n = 0; n < 50 && icdone !== 1'b1; n++) begin
      @(posedge CLK_I);
      #1;
    end
    chk_bit("ic done", 1'b1, icdone);
    if (!w) chk_vec("ic rdata", {32'h0000_0000, e}, {32'h0000_0000, icrd});
  endtask
  // Each access start must match the oldest expected access; looked at mid-cycle.
  always @(negedge CLK_I) begin
    if (acc_start === 1'b1) begin
      chk_vec("access", qa.size() > 0 ? qa.pop_front() : 'x, {acc_kind, acc_reg, acc_write,
        acc_write ? acc_wd : 32'h0000_0000});
    end
  end
  // Watchdog; the tests need a few thousand cycles at most.
  initial begin
    #100us;
    err_count++;
    final_report();
  end
  // Main sequence.
  initial begin
    void'($urandom(55361));
    {unsol, txf, sold, merr, rerr, oph, oemp, iph, ifull, iemp} = '0;
    {icm, icw, dval, lock, iclr, req, reqw, icgo, icwr, iso} = '0;
    {ecode, icaddr, icwd, reqa, regrd, reqwd} = '0;
    reqk = hostport_pkg::ACC_NONE;
    repeat (20) @(posedge CLK_I);
    @(negedge CLK_I);
    NRST_I = 1'b1;
    for (int i = 0; i < 10; i++) local_op(i[0], i / 2 + 1, 4'($urandom()));
    $display("test local transfers done");
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: pulse(unsol);
        1: pulse(txf);
        2: pulse(sold);
        default: pulse(merr);
      endcase
      chk_bit("message irq", 1'b1, bus_if.message_irq);
      pulse(iclr);
      chk_bit("message irq", 1'b0, bus_if.message_irq);
    end
    ecode = $urandom();
    pulse(rerr);
    chk_bit("error irq", 1'b1, bus_if.error_irq);
    chk_bit("message irq", 1'b0, bus_if.message_irq);
    ic_op(1'b0, 8'($urandom_range(0, 31)), ecode);
    ic_op(1'b0, 8'h40, 8'hFF);
    pulse(iclr);
    chk_bit("error irq", 1'b0, bus_if.error_irq);
    $display("test interrupts done");
    for (int i = 0; i < 4; i++) begin
      @(negedge CLK_I);
      {oph, oemp} = 2'(i);
      #1;
      chk_bit("out dma", i == 3, bus_if.out_dma_request);
    end
    pulse(ifull);
    chk_bit("in dma", 1'b0, bus_if.in_dma_request);
    iph = 1'b1;
    pulse(ifull);
    pulse(oph);
    chk_bit("in dma", 1'b1, bus_if.in_dma_request);
    pulse(iemp);
    chk_bit("in dma", 1'b0, bus_if.in_dma_request);
    @(negedge CLK_I);
    oph = 1'b1;
    #1;
    chk_bit("out dma", 1'b1, bus_if.out_dma_request);
    local_op(1'b1, 5, 4'h0);
    @(negedge CLK_I);
    oemp = 1'b0;
    #1;
    chk_bit("out dma", 1'b0, bus_if.out_dma_request);
    $display("test dma done");
    pulse(icm);
    chk_bit("ic request", 1'b1, bus_if.ic_request);
    ic_op(1'b0, 8'h02, ecode);
    chk_bit("ic request", 1'b0, bus_if.ic_request);
    icw = 1'b1;
    pulse(icm);
    chk_bit("ic request", 1'b0, bus_if.ic_request);
    pulse(dval);
    chk_bit("ic request", 1'b1, bus_if.ic_request);
    pulse(lock);
    lock = 1'b1;
    pulse(iclr);
    chk_bit("ic request", 1'b0, bus_if.ic_request);
    lock = 1'b0;
    pulse(oph);
    chk_bit("ic request", 1'b1, bus_if.ic_request);
    ic_op(1'b1, 8'h03, 8'h00);
    chk_bit("ic request", 1'b0, bus_if.ic_request);
    $display("test interconnect done");
    pulse(unsol);
    @(negedge CLK_I);
    iso = 1'b1;
    #1;
    chk_bit("outputs enabled", 1'b0, bus_if.outputs_enabled);
    chk_bit("message irq", 1'b0, bus_if.message_irq);
    @(negedge CLK_I);
    iso = 1'b0;
    #1;
    chk_bit("outputs enabled", 1'b1, bus_if.outputs_enabled);
    chk_bit("message irq", 1'b1, bus_if.message_irq);
    pulse(iclr);
    $display("test isolation done");
    final_report();
  end
endmodule
`default_nettype wire
